// ---- rtl/sas_defines.vh ----
// Constants for the converter sequencer: register offsets, fields, resets, timing.
// Assumes a 125 MHz system clock and an APB master with 32-bit data.
//
// Notes on behaviour
// - Every result delivered and stored is 12 bits wide.
// - Eight external channels are selected through the input multiplexer.
// - Single mode converts only the software-chosen channel.
// - Auto mode steps through the chosen channel set without software help.
// - Temperature and battery inputs are never part of auto mode.
// - Channels 0..3 raise an alert when a result passes its threshold.
// - Alert changes only after 1 to 8 consecutive confirming results.
// - DMA streams results; one interrupt when the programmed count is written.
// - Optional averaging over 1 to 256 samples per channel.
// - Each channel, temperature and battery included, has its own result register.
// - Conversion rate programmable from 10 kSPS up to 1.8 MSPS.
// - Software picks internal or external reference, internal 1.25 V or 2.50 V.
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

// Register byte offsets
`define SAS_CTRL      8'h00
`define SAS_CHSEL     8'h04
`define SAS_RATE      8'h08
`define SAS_AVG       8'h0c
`define SAS_DMACNT    8'h10
`define SAS_ALCFG     8'h14
`define SAS_THR0      8'h18
`define SAS_STAT      8'h28
`define SAS_MASK      8'h2c
`define SAS_RES0      8'h30

// Control fields
`define SAS_C_EN      0
`define SAS_C_AUTO    1
`define SAS_C_DMA     2
`define SAS_C_AVG     3
`define SAS_C_REFEXT  4
`define SAS_C_REFHI   5
`define SAS_C_START   6

// Status fields
`define SAS_S_CONV    0
`define SAS_S_DMA     1
`define SAS_S_ALERT   2

// Channel codes beyond the eight external inputs
`define SAS_CH_TEMP   4'h8
`define SAS_CH_BATT   4'h9
`define SAS_NCH       10

// Reset values
`define SAS_CTRL_RST  6'h00
`define SAS_RATE_RST  14'h0046
`define SAS_ALCFG_RST 11'h000

// Timing: rates in samples per second, clock in Hz
`define SAS_CLK_HZ    125000000
`define SAS_MAX_SPS   1800000
`define SAS_MIN_SPS   10000
`define SAS_RATE_MIN  ((`SAS_CLK_HZ + `SAS_MAX_SPS - 1) / `SAS_MAX_SPS)
`define SAS_RATE_MAX  (`SAS_CLK_HZ / `SAS_MIN_SPS)
`define SAS_AVG_LMAX  4'h8

`endif

// ---- rtl/sas_sequencer.v ----
// Sequencer and register file for a 12-bit SAR converter subsystem.
// Assumes the analog core pulses conv_done with conv_data one cycle or more after conv_start.
//
// The implementer's own choices: the APB slave port and the address map.
`default_nettype none
`include "sas_defines.vh"

module sas_sequencer (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Converter core
    output reg         conv_start,
    output reg  [3:0]  conv_chan,
    output reg         ref_ext,
    output reg         ref_hi,
    input  wire        conv_done,
    input  wire [11:0] conv_data,
    // DMA channel
    output reg         dma_req,
    output reg  [15:0] dma_data,
    input  wire        dma_ack,
    // Interrupt
    output reg         irq
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;
    // Rate limits are computed as integers and cut to the 14-bit period field
    localparam integer RMIN_I = `SAS_RATE_MIN;
    localparam integer RMAX_I = `SAS_RATE_MAX;
    localparam [13:0] RMIN = RMIN_I[13:0];
    localparam [13:0] RMAX = RMAX_I[13:0];

    // First enabled channel at or above 'from', else lowest enabled
    // The second pass overrides the wrap choice, so ascending order wins when any
    // channel lies at or above the pointer; an empty mask yields channel 0 but is
    // never started because go requires a non-empty mask in auto mode.
    function [2:0] first_at;
        input [7:0] mask;
        input [2:0] from;
        integer i;
        begin
            first_at = 3'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (mask[i]) begin
                    first_at = i[2:0];
                end
            end
            for (i = 7; i >= 0; i = i - 1) begin
                if (mask[i] && (i[2:0] >= from)) begin
                    first_at = i[2:0];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [5:0]  ctrl_ff;
    reg  [3:0]  sel_ff;
    reg  [7:0]  amask_ff;
    reg  [13:0] rate_ff;
    reg  [3:0]  avgl_ff;
    reg  [15:0] dcnt_ff;
    reg  [10:0] alcfg_ff;
    reg  [11:0] thr_ff [0:3];
    reg  [11:0] res_ff [0:`SAS_NCH-1];
    reg  [5:0]  stat_ff;
    reg  [5:0]  mask_ff;
    reg         spend_ff;
    reg  [15:0] dleft_ff;

    // Sequencer state
    reg  [2:0]  st_ff;
    reg  [13:0] tmr_ff;
    reg  [2:0]  cur_ff;
    reg  [19:0] acc_ff;
    reg  [8:0]  smp_ff;
    reg  [3:0]  alst_ff;
    reg  [2:0]  hcnt_ff [0:3];

    wire        wr_en   = psel & ~penable & pwrite;
    wire        rd_en   = psel & ~penable & ~pwrite;
    wire        en      = ctrl_ff[`SAS_C_EN];
    wire        auto    = ctrl_ff[`SAS_C_AUTO];
    wire [7:0]  mask8   = amask_ff;
    wire [13:0] rate_c  = (rate_ff < RMIN) ? RMIN :
                          ((rate_ff > RMAX) ? RMAX : rate_ff);
    wire        tick    = (tmr_ff == 14'h0000);
    wire [3:0]  avgl_c  = (avgl_ff > `SAS_AVG_LMAX) ? `SAS_AVG_LMAX : avgl_ff;
    wire [8:0]  smp_tgt = ctrl_ff[`SAS_C_AVG] ? (9'h001 << avgl_c) : 9'h001;
    wire        go      = en & (auto ? (|mask8) : spend_ff);
    wire [2:0]  auto_ch = first_at(mask8, cur_ff);
    wire [3:0]  pick_ch = auto ? {1'b0, auto_ch} : sel_ff;

    // Completion of a result
    wire [19:0] acc_n   = acc_ff + {8'h00, conv_data};
    wire [8:0]  smp_n   = smp_ff + 9'h001;
    wire        fin     = (st_ff == ST_CONV) & conv_done & (smp_n == smp_tgt);
    wire [19:0] avg_sh  = acc_n >> avgl_c;
    wire [11:0] result  = ctrl_ff[`SAS_C_AVG] ? avg_sh[11:0] : conv_data;

    // Alert evaluation for the channel just finished
    wire [1:0]  ach     = conv_chan[1:0];
    wire        al_on   = fin & (conv_chan[3:2] == 2'b00) & alcfg_ff[ach];
    wire        above   = alcfg_ff[4 + ach];
    wire        cond    = above ? (result > thr_ff[ach]) : (result < thr_ff[ach]);
    wire        flip    = al_on & (cond != alst_ff[ach]) &
                          (hcnt_ff[ach] >= alcfg_ff[10:8]);

    // DMA push and done
    wire        dpush   = fin & ctrl_ff[`SAS_C_DMA] & (dleft_ff != 16'h0000);
    wire        dtake   = dma_req & dma_ack;
    wire        ddone   = dtake & (dleft_ff == 16'h0001);

    // Status set and clear; set wins
    // A clear written in the same cycle as a new event leaves the bit set, so
    // software never loses an event that lands during its own acknowledge.
    reg  [5:0]  sset;
    wire [5:0]  sclr    = (wr_en && paddr == `SAS_STAT) ? pwdata[5:0] : 6'h00;
    wire [5:0]  nxt_stat = (stat_ff & ~sclr) | sset;

    always @* begin
        sset = 6'h00;
        sset[`SAS_S_CONV] = fin;
        sset[`SAS_S_DMA]  = ddone;
        if (flip && !alst_ff[ach]) begin
            sset[`SAS_S_ALERT + ach] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB write side
    integer k;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff  <= `SAS_CTRL_RST;
            sel_ff   <= 4'h0;
            amask_ff <= 8'h00;
            rate_ff  <= `SAS_RATE_RST;
            avgl_ff  <= 4'h0;
            dcnt_ff  <= 16'h0000;
            alcfg_ff <= `SAS_ALCFG_RST;
            mask_ff  <= 6'h00;
            stat_ff  <= 6'h00;
            spend_ff <= 1'b0;
            dleft_ff <= 16'h0000;
            for (k = 0; k < 4; k = k + 1) begin
                thr_ff[k] <= 12'h000;
            end
        end else begin
            stat_ff <= nxt_stat;
            if (fin && !auto) begin
                spend_ff <= 1'b0;
            end
            if (dtake) begin
                dleft_ff <= dleft_ff - 16'h0001;
            end
            if (wr_en) begin
                case (paddr)
                    `SAS_CTRL: begin
                        ctrl_ff <= pwdata[5:0];
                        if (pwdata[`SAS_C_START]) begin
                            spend_ff <= 1'b1;
                        end
                    end
                    `SAS_CHSEL: begin
                        // Codes above battery fold onto battery
                        sel_ff   <= (pwdata[3:0] > `SAS_CH_BATT) ? `SAS_CH_BATT : pwdata[3:0];
                        amask_ff <= pwdata[15:8];
                    end
                    `SAS_RATE:   rate_ff  <= pwdata[13:0];
                    `SAS_AVG:    avgl_ff  <= pwdata[3:0];
                    `SAS_DMACNT: begin
                        dcnt_ff  <= pwdata[15:0];
                        dleft_ff <= pwdata[15:0];
                    end
                    `SAS_ALCFG:  alcfg_ff <= pwdata[10:0];
                    `SAS_MASK:   mask_ff  <= pwdata[5:0];
                    8'h18, 8'h1c, 8'h20, 8'h24: thr_ff[paddr[3:2] - 2'b10] <= pwdata[11:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read side: data prepared in setup, presented in access
    reg  [31:0] rd_val;
    reg         rd_err;
    wire [7:0]  roff = paddr - `SAS_RES0;
    always @* begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            `SAS_CTRL:   rd_val = {26'h0, ctrl_ff};
            `SAS_CHSEL:  rd_val = {16'h0, amask_ff, 4'h0, sel_ff};
            `SAS_RATE:   rd_val = {18'h0, rate_ff};
            `SAS_AVG:    rd_val = {28'h0, avgl_ff};
            `SAS_DMACNT: rd_val = {dleft_ff, dcnt_ff};
            `SAS_ALCFG:  rd_val = {17'h0, alst_ff, alcfg_ff};
            `SAS_STAT:   rd_val = {26'h0, stat_ff};
            `SAS_MASK:   rd_val = {26'h0, mask_ff};
            8'h18, 8'h1c, 8'h20, 8'h24: rd_val = {20'h0, thr_ff[paddr[3:2] - 2'b10]};
            default: begin
                if (paddr >= `SAS_RES0 && roff[7:2] < `SAS_NCH && paddr[1:0] == 2'b00) begin
                    rd_val = {20'h0, res_ff[roff[5:2]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
            ref_ext <= 1'b0;
            ref_hi  <= 1'b0;
        end else begin
            pready  <= 1'b1;
            if (psel && !penable) begin
                prdata  <= rd_en ? rd_val : 32'h0000_0000;
                // Unmapped writes are silently dropped, only reads report an error
                pslverr <= rd_en & rd_err;
            end
            irq     <= |(nxt_stat & mask_ff);
            ref_ext <= ctrl_ff[`SAS_C_REFEXT];
            ref_hi  <= ctrl_ff[`SAS_C_REFHI];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    // One conversion is in flight at a time: the core answers whenever it is
    // ready and the sequencer simply waits, so a slow core lowers the real rate
    // below the programmed one rather than overlapping conversions.
    integer m;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff      <= ST_IDLE;
            tmr_ff     <= 14'h0000;
            cur_ff     <= 3'h0;
            acc_ff     <= 20'h00000;
            smp_ff     <= 9'h000;
            conv_start <= 1'b0;
            conv_chan  <= 4'h0;
            dma_req    <= 1'b0;
            dma_data   <= 16'h0000;
            alst_ff    <= 4'h0;
            for (m = 0; m < `SAS_NCH; m = m + 1) begin
                res_ff[m] <= 12'h000;
            end
            for (m = 0; m < 4; m = m + 1) begin
                hcnt_ff[m] <= 3'h0;
            end
        end else begin
            conv_start <= 1'b0;
            // Sample clock runs only while enabled, so a start lines up with the period
            if (!en || tick) begin
                tmr_ff <= rate_c - 14'h0001;
            end else begin
                tmr_ff <= tmr_ff - 14'h0001;
            end
            if (dtake) begin
                dma_req <= 1'b0;
            end
            case (st_ff)
                ST_IDLE: begin
                    // A pending DMA word stalls the next start rather than overwrite it
                    if (go && tick && !dma_req) begin
                        conv_start <= 1'b1;
                        conv_chan  <= pick_ch;
                        if (auto) begin
                            cur_ff <= auto_ch;
                        end
                        st_ff <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        if (fin) begin
                            acc_ff <= 20'h00000;
                            smp_ff <= 9'h000;
                            res_ff[conv_chan] <= result;
                            cur_ff <= cur_ff + 3'h1;
                            if (dpush) begin
                                dma_req  <= 1'b1;
                                dma_data <= {conv_chan, result};
                            end
                        end else begin
                            acc_ff <= acc_n;
                            smp_ff <= smp_n;
                        end
                        st_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    st_ff <= ST_IDLE;
                end
                default: st_ff <= ST_IDLE;
            endcase
            // Hysteresis: a disagreeing result only counts; the state flips once
            // the count has reached the programmed depth, agreeing results reset it.
            if (al_on) begin
                if (flip) begin
                    alst_ff[ach] <= cond;
                    hcnt_ff[ach] <= 3'h0;
                end else if (cond != alst_ff[ach]) begin
                    hcnt_ff[ach] <= hcnt_ff[ach] + 3'h1;
                end else begin
                    hcnt_ff[ach] <= 3'h0;
                end
            end
        end
    end

endmodule // sas_sequencer
`default_nettype wire

// ---- dv/sas_sequencer_asserts.sv ----
// Port checker for the converter sequencer.
// Assumes one clock, asynchronous active-high reset, zero-wait APB.
`default_nettype none
module sas_sequencer_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Converter, DMA, interrupt
    input wire logic        conv_start,
    input wire logic [3:0]  conv_chan,
    input wire logic        ref_ext,
    input wire logic        ref_hi,
    input wire logic        conv_done,
    input wire logic [11:0] conv_data,
    input wire logic        dma_req,
    input wire logic [15:0] dma_data,
    input wire logic        dma_ack,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    logic [6:0] gap_ff;
    logic       auto_ff;
    logic [1:0] ref_ff;
    wire        ctrl_wr = psel && !penable && pwrite && paddr == 8'h00;
    wire        bad_adr = paddr > 8'h54 || paddr[1:0] != 2'h0;
    // Gap saturates so the first start after reset is never judged
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_ff  <= 7'h7f;
            auto_ff <= 1'b0;
            ref_ff  <= 2'h0;
        end else begin
            if (conv_start)
                gap_ff <= 7'h00;
            else if (gap_ff != 7'h7f)
                gap_ff <= gap_ff + 7'h01;
            if (ctrl_wr)
                auto_ff <= pwdata[1];
            if (ctrl_wr)
                ref_ff <= pwdata[5:4];
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_rd_setup; psel && !penable && !pwrite; endsequence
    sequence s_access; psel && penable; endsequence
    property p_zero_wait; s_access |-> pready; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("access without pready");
    property p_unmapped; s_rd_setup ##1 s_access |-> pslverr == $past(bad_adr); endproperty
    a_unmapped: assert property (p_unmapped) else $error("pslverr wrong for read address");
    property p_chan_range; conv_start |-> conv_chan <= 4'h9; endproperty
    a_chan_range: assert property (p_chan_range) else $error("start on unknown channel");
    property p_auto_ext; auto_ff && conv_start |-> conv_chan < 4'h8; endproperty
    a_auto_ext: assert property (p_auto_ext) else $error("internal input in auto mode");
    property p_chan_hold; $changed(conv_chan) |-> conv_start; endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved without a start");
    property p_gap; conv_start |-> gap_ff >= 7'h45; endproperty
    a_gap: assert property (p_gap) else $error("starts closer than the fastest rate");
    property p_dma_hold; dma_req && !dma_ack |=> dma_req && $stable(dma_data); endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("DMA word dropped before taken");
    property p_dma_take; dma_req && dma_ack |=> !dma_req; endproperty
    a_dma_take: assert property (p_dma_take) else $error("DMA request stays after take");
    property p_ref; ctrl_wr |=> ##[0:1] (ref_ext == ref_ff[0] && ref_hi == ref_ff[1]); endproperty
    a_ref: assert property (p_ref) else $error("reference select not applied");
endmodule // sas_sequencer_asserts
bind sas_sequencer sas_sequencer_asserts sas_sequencer_asserts_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start(conv_start), .conv_chan(conv_chan), .ref_ext(ref_ext), .ref_hi(ref_hi),
    .conv_done(conv_done), .conv_data(conv_data), .dma_req(dma_req), .dma_data(dma_data), .dma_ack(dma_ack),
    .irq(irq));
`default_nettype wire

// ---- dv/sas_conv_model.sv ----
// Behavioural SAR core and input multiplexer.
// Assumes conv_chan holds until the next start; answers 2 or 6 cycles after a start.
`default_nettype none
module sas_conv_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Converter handshake
    input  wire logic        conv_start,
    input  wire logic [3:0]  conv_chan,
    input  wire logic        slow,
    output var  logic        conv_done,
    output var  logic [11:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_ff;
    logic [1:0] cnt_ff;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_ff   <= 3'h0;
            cnt_ff    <= 2'h0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            // Data is not held outside the done pulse
            conv_data <= ~conv_data;
            if (conv_start)
                wait_ff <= slow ? 3'h5 : 3'h1;
            else if (wait_ff == 3'h1) begin
                conv_done <= 1'b1;
                conv_data <= 12'h05a + {conv_chan, 8'h00} + {10'h000, cnt_ff};
                cnt_ff    <= cnt_ff + 2'h1;
            end
            if (!conv_start && wait_ff != 3'h0)
                wait_ff <= wait_ff - 3'h1;
        end
    end
endmodule // sas_conv_model
`default_nettype wire

// ---- dv/sar_adc_sequencer_bench.sv ----
// Self-checking bench for the converter sequencer with a behavioural core.
// Assumes sas_defines.vh on the include path; the bench acknowledges DMA words.
`default_nettype none
`include "sas_defines.vh"
module sar_adc_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dma_ack = 1'b0, slow = 1'b0;
    logic        pready, pslverr, conv_start, ref_ext, ref_hi, conv_done, dma_req, irq, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  conv_chan;
    logic [11:0] conv_data;
    logic [15:0] dma_data;
    logic [3:0]  starts[$];
    int          n_errors = 0, n_tests = 0;
    sas_sequencer sas_sequencer_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
        .conv_chan(conv_chan), .ref_ext(ref_ext), .ref_hi(ref_hi), .conv_done(conv_done), .conv_data(conv_data),
        .dma_req(dma_req), .dma_data(dma_data), .dma_ack(dma_ack), .irq(irq));
    sas_conv_model sas_conv_model_inst (.clk(clk), .rst(rst), .conv_start(conv_start), .conv_chan(conv_chan),
        .slow(slow), .conv_done(conv_done), .conv_data(conv_data));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (conv_start === 1'b1) starts.push_back(conv_chan);
    ////////////////////////////////////////////////////////////
    function automatic logic [11:0] val(input logic [3:0] ch, input int i);
        return 12'h05a + {ch, 8'h00} + 12'(i % 4);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (k >= 20) begin
            n_errors++;
            give_verdict;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Kinds: 0 status bit n, 1 start count n, 2 DMA request, 3 interrupt
    task automatic wait_for(input int what, input int n);
        int  k;
        logic ok;
        k = 0;
        ok = 1'b0;
        while (!ok && k < 2000) begin
            if (what == 0)
                apb(1'b0, `SAS_STAT, 32'h0);
            else
                @(posedge clk);
            ok = what == 0 ? rd[n] === 1'b1 : what == 1 ? starts.size() >= n : what == 2 ? dma_req === 1'b1 : irq === 1'b1;
            k++;
        end
        if (!ok) begin
            n_errors++;
            give_verdict;
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        rdc(`SAS_CTRL, 32'h0);
        rdc(`SAS_RATE, {18'h0, `SAS_RATE_RST});
        rdc(`SAS_ALCFG, 32'h0);
        rdc(8'h58, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `SAS_RATE, 32'h3fff);
        // The period register reads back as written; clamping acts on the timer
        rdc(`SAS_RATE, 32'h3fff);
        apb(1'b1, `SAS_RATE, 32'h5);
        rdc(`SAS_RATE, 32'h5);
        apb(1'b1, `SAS_AVG, 32'h9);
        rdc(`SAS_AVG, 32'h9);
    endtask
    task automatic t_single;
        logic [3:0] ch;
        int         n;
        for (int i = 0; i < 3; i++) begin
            ch = (i == 0) ? 4'h3 : 4'(7 + i);
            slow <= i[0];
            apb(1'b1, `SAS_CHSEL, {28'h0, ch});
            n = starts.size();
            apb(1'b1, `SAS_CTRL, 32'h41 | (i << 4));
            chk({30'h0, ref_hi, ref_ext}, i);
            wait_for(0, `SAS_S_CONV);
            repeat (150) @(posedge clk);
            chk(starts.size(), n + 1);
            chk(starts[n], ch);
            rdc(`SAS_RES0 + 8'(4 * ch), val(ch, n));
            apb(1'b1, `SAS_STAT, 32'h1);
            rdc(`SAS_STAT, 32'h0);
        end
    endtask
    task automatic t_auto;
        int n;
        n = starts.size();
        apb(1'b1, `SAS_CHSEL, 32'hc109);
        apb(1'b1, `SAS_CTRL, 32'h3);
        wait_for(1, n + 5);
        apb(1'b1, `SAS_CTRL, 32'h0);
        for (int j = n; j < n + 4; j++)
            chk(starts[j + 1], starts[j] == 0 ? 6 : starts[j] == 6 ? 7 : 0);
        repeat (20) @(posedge clk);
        apb(1'b1, `SAS_STAT, 32'h1);
    endtask
    task automatic t_avg;
        int n;
        n = starts.size();
        apb(1'b1, `SAS_AVG, 32'h2);
        apb(1'b1, `SAS_CHSEL, 32'h5);
        apb(1'b1, `SAS_CTRL, 32'h49);
        wait_for(0, `SAS_S_CONV);
        chk(starts.size(), n + 4);
        rdc(`SAS_RES0 + 8'h14, val(4'h5, 1));
        apb(1'b1, `SAS_CTRL, 32'h0);
        apb(1'b1, `SAS_STAT, 32'h1);
    endtask
    task automatic t_alert;
        apb(1'b1, `SAS_ALCFG, 32'h122);
        apb(1'b1, `SAS_THR0 + 8'h4, 32'h100);
        apb(1'b1, `SAS_MASK, 32'h8);
        apb(1'b1, `SAS_CHSEL, 32'h1);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, `SAS_CTRL, 32'h41);
            wait_for(0, `SAS_S_CONV);
            rdc(`SAS_ALCFG, 32'h122 | (j << 12));
            rdc(`SAS_STAT, 32'h1 | (j << 3));
            chk({31'h0, irq}, j);
            apb(1'b1, `SAS_STAT, 32'h1);
        end
        apb(1'b1, `SAS_STAT, 32'h8);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_dma;
        int n;
        apb(1'b1, `SAS_DMACNT, 32'h2);
        apb(1'b1, `SAS_MASK, 32'h2);
        apb(1'b1, `SAS_CHSEL, 32'h0400);
        apb(1'b1, `SAS_CTRL, 32'h7);
        for (int j = 0; j < 2; j++) begin
            wait_for(2, 0);
            n = starts.size();
            // Stall the memory side well past one sample period
            repeat (100) @(posedge clk);
            chk(starts.size(), n);
            chk(dma_data, {4'h2, val(4'h2, n - 1)});
            dma_ack <= 1'b1;
            @(posedge clk);
            dma_ack <= 1'b0;
        end
        wait_for(3, 0);
        rdc(`SAS_DMACNT, 32'h2);
        apb(1'b1, `SAS_CTRL, 32'h0);
        chk({31'h0, dma_req}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_single;
        t_auto;
        t_avg;
        t_alert;
        t_dma;
        give_verdict;
    end
endmodule // sar_adc_sequencer_bench
`default_nettype wire
